// File: src/pcfu_top.sv
module pcfu_top #(
    parameter int HI_W = pcfu_pkg::PCFU_HI_W
) (
    input wire logic REF_CLK,
    input wire logic RST_N,
    input wire logic [11:0] PADDR,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [31:0] PWDATA,
    input wire logic [3:0] PSTRB,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    output logic [HI_W+7:0] PM_ADDR,
    output logic PM_RD,
    input wire logic [15:0] PM_DATA,
    output logic [15:0] INSTR,
    output logic INSTR_VALID,
    output logic [1:0] PHASE,
    output logic [HI_W+7:0] EXEC_PC,
    input wire logic CORE_EXTENDED,
    input wire logic CORE_BRANCH,
    input wire logic [HI_W+7:0] CORE_TARGET,
    input wire logic CORE_SKIP,
    input wire logic CORE_IRQ,
    input wire logic [HI_W+7:0] CORE_VECTOR
);
    localparam int LO_W = pcfu_pkg::PCFU_LO_W;
    localparam int AW = HI_W + LO_W;

    // ==========================================================
    // Phase generator
    pcfu_phase_if ph_if();

    pcfu_phase u_phase (
        .clk(REF_CLK),
        .rst_n(RST_N),
        .ph(ph_if)
    );

    logic ph_last;
    pcfu_pkg::pcfu_phase_e ph_now;
    assign ph_last = ph_if.last;
    assign ph_now = ph_if.phase;

    // ==========================================================
    // Sequencing state
    logic [AW-1:0] pm_addr_ff;
    logic [AW-1:0] pc_ff;
    logic [AW-1:0] exec_pc_ff;
    logic [15:0] instr_ff;
    pcfu_pkg::pcfu_exec_e exec_st_ff;
    pcfu_pkg::pcfu_exec_e nxt_exec_st;
    logic wr_pend_ff;
    logic [LO_W-1:0] wr_val_ff;
    logic [7:0] hold_ff;

    logic valid;
    logic ext_first;
    logic br;
    logic skp;
    logic redir;
    logic discard;
    logic wr_used;
    logic [AW-1:0] nxt_fetch;

    assign valid = (exec_st_ff != pcfu_pkg::PCFU_X_DUMMY);
    assign br = valid & CORE_BRANCH;
    assign skp = valid & CORE_SKIP;
    // First cycle of an extended word holds the fetch for one more cycle
    assign ext_first = valid & CORE_EXTENDED & (exec_st_ff == pcfu_pkg::PCFU_X_NORM);

    // Target choice: interrupt, then branch, then low byte write
    always_comb
    begin
        nxt_fetch = pc_ff;
        redir = 1'b1;
        wr_used = 1'b0;
        if (CORE_IRQ)
            nxt_fetch = CORE_VECTOR;
        else if (br)
            nxt_fetch = CORE_TARGET;
        else if (wr_pend_ff)
        begin
            nxt_fetch = {pc_ff[AW-1:LO_W], wr_val_ff};
            wr_used = 1'b1;
        end
        else
            redir = 1'b0;
    end

    assign discard = redir | skp;

    always_comb
    begin
        unique case (exec_st_ff)
            pcfu_pkg::PCFU_X_NORM:
                nxt_exec_st = ext_first ? pcfu_pkg::PCFU_X_EXT2 :
                    (discard ? pcfu_pkg::PCFU_X_DUMMY : pcfu_pkg::PCFU_X_NORM);
            pcfu_pkg::PCFU_X_EXT2,
            pcfu_pkg::PCFU_X_DUMMY:
                nxt_exec_st = discard ? pcfu_pkg::PCFU_X_DUMMY : pcfu_pkg::PCFU_X_NORM;
            default:
                nxt_exec_st = pcfu_pkg::PCFU_X_DUMMY;
        endcase
    end

    // Redirects and skips replace the next word with a dummy cycle
    always_ff @(posedge REF_CLK)
    begin
        if (!RST_N)
            exec_st_ff <= pcfu_pkg::PCFU_X_DUMMY;
        else if (ph_last)
            exec_st_ff <= nxt_exec_st;
    end

    // Fetch address and counter step at the start of the first phase
    always_ff @(posedge REF_CLK)
    begin
        if (!RST_N)
        begin
            pm_addr_ff <= AW'(pcfu_pkg::PCFU_RST_VEC);
            pc_ff <= AW'(pcfu_pkg::PCFU_RST_VEC) + AW'(1);
        end
        else if (ph_last && !ext_first)
        begin
            pm_addr_ff <= nxt_fetch;
            pc_ff <= nxt_fetch + AW'(1);
        end
    end

    // Fetched word moves to execute while phases two to four run it
    always_ff @(posedge REF_CLK)
    begin
        if (!RST_N)
        begin
            instr_ff <= pcfu_pkg::PCFU_NOP_WORD;
            exec_pc_ff <= AW'(pcfu_pkg::PCFU_RST_VEC);
        end
        else if (ph_last && !ext_first)
        begin
            instr_ff <= PM_DATA;
            exec_pc_ff <= pm_addr_ff;
        end
    end

    // ==========================================================
    // APB slave
    logic rdy_ff;
    logic [31:0] prdata_ff;
    logic hit;
    logic acc_first;
    logic acc_done;
    logic wr_take;
    logic snap_rd;
    logic [31:0] rd_mux;

    assign hit = (PADDR == pcfu_pkg::PCFU_OFF_CNT_LOW) ||
                 (PADDR == pcfu_pkg::PCFU_OFF_SNAP_LOW) ||
                 (PADDR == pcfu_pkg::PCFU_OFF_SNAP_HIGH) ||
                 (PADDR == pcfu_pkg::PCFU_OFF_STATUS);
    assign acc_first = PSEL & PENABLE & ~rdy_ff;
    assign acc_done = PSEL & PENABLE & rdy_ff;
    assign wr_take = acc_done & PWRITE & PSTRB[0] &
                     (PADDR == pcfu_pkg::PCFU_OFF_CNT_LOW);
    assign snap_rd = acc_first & ~PWRITE & (PADDR == pcfu_pkg::PCFU_OFF_SNAP_LOW);

    always_comb
    begin
        rd_mux = 32'h0000_0000;
        if (PADDR == pcfu_pkg::PCFU_OFF_CNT_LOW)
            rd_mux = 32'(pc_ff[LO_W-1:0]);
        else if (PADDR == pcfu_pkg::PCFU_OFF_SNAP_LOW)
            rd_mux = 32'(exec_pc_ff[LO_W-1:0]);
        else if (PADDR == pcfu_pkg::PCFU_OFF_SNAP_HIGH)
            rd_mux = 32'(hold_ff);
        else if (PADDR == pcfu_pkg::PCFU_OFF_STATUS)
        begin
            rd_mux[pcfu_pkg::PCFU_ST_PH_LSB +: 2] = ph_now;
            rd_mux[pcfu_pkg::PCFU_ST_EX_LSB +: 2] = exec_st_ff;
        end
    end

    // One wait state so read data comes from a flop
    always_ff @(posedge REF_CLK)
    begin
        if (!RST_N)
            rdy_ff <= 1'b0;
        else
            rdy_ff <= acc_first;
    end

    always_ff @(posedge REF_CLK)
    begin
        if (!RST_N)
            prdata_ff <= 32'h0000_0000;
        else if (acc_first && !PWRITE)
            prdata_ff <= rd_mux;
    end

    assign PREADY = rdy_ff;
    assign PSLVERR = rdy_ff & ~hit;
    assign PRDATA = prdata_ff;

    // ==========================================================
    // Low byte write: pending until an instruction boundary with no interrupt or branch
    always_ff @(posedge REF_CLK)
    begin
        if (!RST_N)
        begin
            wr_pend_ff <= 1'b0;
            wr_val_ff <= pcfu_pkg::PCFU_SNAP_RST;
        end
        else if (wr_take)
        begin
            wr_pend_ff <= 1'b1;
            wr_val_ff <= PWDATA[LO_W-1:0];
        end
        else if (ph_last && !ext_first && wr_used)
            wr_pend_ff <= 1'b0;
    end

    // ==========================================================
    // Snapshot high holding byte, written only by a snapshot low read
    always_ff @(posedge REF_CLK)
    begin
        if (!RST_N)
            hold_ff <= pcfu_pkg::PCFU_SNAP_RST;
        else if (snap_rd)
            hold_ff <= 8'(exec_pc_ff[AW-1:LO_W]);
    end

    // ==========================================================
    // Outputs
    assign PM_ADDR = pm_addr_ff;
    assign PM_RD = (ph_now == pcfu_pkg::PCFU_T1) && (exec_st_ff != pcfu_pkg::PCFU_X_EXT2);
    assign INSTR = instr_ff;
    assign INSTR_VALID = valid;
    assign PHASE = ph_now;
    assign EXEC_PC = exec_pc_ff;

    // ==========================================================
    // Assertions
    default clocking cb @(posedge REF_CLK);
    endclocking

    default disable iff (!RST_N);

    property p_phase_period;
        ph_last |=> !ph_last [*3] ##1 ph_last;
    endproperty
    a_phase_period: assert property (p_phase_period)
        else $error("phase sequence is not four cycles");

    property p_fetch_t1;
        !$stable(PM_ADDR) |-> $past(ph_last) && ph_now == pcfu_pkg::PCFU_T1;
    endproperty
    a_fetch_t1: assert property (p_fetch_t1)
        else $error("fetch address moved outside the first phase");

    property p_exec_hold;
        !$stable(INSTR) |-> ph_now == pcfu_pkg::PCFU_T1;
    endproperty
    a_exec_hold: assert property (p_exec_hold)
        else $error("executing word changed during phases two to four");

    property p_ext;
        ph_last && ext_first && !discard |=>
            ($stable(INSTR) && $stable(PM_ADDR)) [*4] ##0 INSTR_VALID;
    endproperty
    a_ext: assert property (p_ext)
        else $error("extended word did not hold for a second cycle");

    property p_seq;
        ph_last && !ext_first && !discard |=> PM_ADDR == AW'($past(PM_ADDR) + AW'(1));
    endproperty
    a_seq: assert property (p_seq)
        else $error("counter did not advance by one");

    property p_branch;
        ph_last && br && !CORE_IRQ && !ext_first |=>
            PM_ADDR == $past(CORE_TARGET) && !INSTR_VALID;
    endproperty
    a_branch: assert property (p_branch)
        else $error("branch did not load target with a dummy cycle");

    property p_skip;
        ph_last && skp && !redir && !ext_first |=>
            !INSTR_VALID && PM_ADDR == AW'($past(PM_ADDR) + AW'(1));
    endproperty
    a_skip: assert property (p_skip)
        else $error("skip did not discard the prefetched word");

    property p_cnt_wr;
        ph_last && wr_used && !ext_first |=>
            PM_ADDR == {$past(pc_ff[AW-1:LO_W]), $past(wr_val_ff)} && !INSTR_VALID;
    endproperty
    a_cnt_wr: assert property (p_cnt_wr)
        else $error("low byte write did not jump within the page");

    property p_snap_latch;
        snap_rd |=> hold_ff == 8'($past(exec_pc_ff[AW-1:LO_W])) &&
            PRDATA == 32'($past(exec_pc_ff[LO_W-1:0]));
    endproperty
    a_snap_latch: assert property (p_snap_latch)
        else $error("snapshot low read did not latch the high part");

    property p_hold_keep;
        !snap_rd |=> $stable(hold_ff);
    endproperty
    a_hold_keep: assert property (p_hold_keep)
        else $error("holding byte changed without a snapshot low read");

    property p_upper_zero;
        hold_ff[7:HI_W] == '0;
    endproperty
    a_upper_zero: assert property (p_upper_zero)
        else $error("unused snapshot high bits are not zero");

    c_branch: cover property (ph_last && br && !CORE_IRQ && !ext_first);
    c_skip: cover property (ph_last && skp && !redir);
    c_ext: cover property (ph_last && ext_first);
    c_snap: cover property (snap_rd ##[1:8] (acc_done && !PWRITE &&
        PADDR == pcfu_pkg::PCFU_OFF_SNAP_HIGH));

endmodule: pcfu_top

// File: src/pcfu_pkg.sv
package pcfu_pkg;

    // ==========================================================
    // Widths
    localparam int PCFU_HI_W = 5;
    localparam int PCFU_LO_W = 8;
    localparam int PCFU_IW = 16;

    // ==========================================================
    // Register map, byte addresses
    localparam logic [11:0] PCFU_OFF_CNT_LOW = 12'h000;
    localparam logic [11:0] PCFU_OFF_SNAP_LOW = 12'h004;
    localparam logic [11:0] PCFU_OFF_SNAP_HIGH = 12'h008;
    localparam logic [11:0] PCFU_OFF_STATUS = 12'h00c;

    // ==========================================================
    // Reset values and fields
    localparam logic [12:0] PCFU_RST_VEC = 13'h0000;
    localparam logic [7:0] PCFU_SNAP_RST = 8'h00;
    localparam logic [15:0] PCFU_NOP_WORD = 16'h0000;
    localparam int PCFU_ST_PH_LSB = 0;
    localparam int PCFU_ST_EX_LSB = 2;

    typedef enum logic [1:0] {
        PCFU_T1 = 2'b00,
        PCFU_T2 = 2'b01,
        PCFU_T3 = 2'b10,
        PCFU_T4 = 2'b11
    } pcfu_phase_e;

    typedef enum logic [1:0] {
        PCFU_X_NORM = 2'b00,
        PCFU_X_EXT2 = 2'b01,
        PCFU_X_DUMMY = 2'b10
    } pcfu_exec_e;

endpackage: pcfu_pkg

// File: src/pcfu_phase_if.sv
interface pcfu_phase_if;
    pcfu_pkg::pcfu_phase_e phase;
    logic last;
    modport gen (output phase, output last);
    modport seq (input phase, input last);
endinterface: pcfu_phase_if

// File: src/pcfu_phase.sv
module pcfu_phase (
    input wire logic clk,
    input wire logic rst_n,
    pcfu_phase_if.gen ph
);
    pcfu_pkg::pcfu_phase_e ph_ff;
    pcfu_pkg::pcfu_phase_e nxt_ph;

    always_comb
    begin
        unique case (ph_ff)
            pcfu_pkg::PCFU_T1: nxt_ph = pcfu_pkg::PCFU_T2;
            pcfu_pkg::PCFU_T2: nxt_ph = pcfu_pkg::PCFU_T3;
            pcfu_pkg::PCFU_T3: nxt_ph = pcfu_pkg::PCFU_T4;
            pcfu_pkg::PCFU_T4: nxt_ph = pcfu_pkg::PCFU_T1;
        endcase
    end

    // Four non-overlapping phases form one instruction cycle
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            ph_ff <= pcfu_pkg::PCFU_T1;
        else
            ph_ff <= nxt_ph;
    end

    assign ph.phase = ph_ff;
    assign ph.last = (ph_ff == pcfu_pkg::PCFU_T4);

endmodule: pcfu_phase

// File: dv/pcfu_pmem_model.sv
module pcfu_pmem_model #(
    parameter int LAT = 2
) (
    input wire logic clk,
    input wire logic rd,
    input wire logic [12:0] addr,
    output logic [15:0] data
);
    timeunit 1ns;
    timeprecision 1ps;

    // ==========================================================
    // Program store: every word carries its own address
    logic [12:0] addr_ff = 13'h0000;
    int wait_ff = 0;

    function automatic logic [15:0] word_at(input logic [12:0] a);
        return {3'h5, a};
    endfunction: word_at

    // Address taken on the fetch strobe, word ready LAT cycles later
    always @(posedge clk)
    begin
        if (rd === 1'b1)
        begin
            addr_ff <= addr;
            wait_ff <= LAT;
        end
        else if (wait_ff > 0)
        begin
            wait_ff <= wait_ff - 1;
        end
    end

    // Until ready the lines show the inverse, never a stale word
    assign data = (wait_ff == 0) ? word_at(addr_ff) : ~word_at(addr_ff);
endmodule: pcfu_pmem_model

// File: dv/pcfu_top_bench.sv
`define CHK(nm, ex, got) \
    begin \
        num_checks++; \
        if ((got) !== (ex)) \
        begin \
            mismatches++; \
            $display("[FAIL] %s expected %h seen %h", nm, ex, got); \
        end \
    end

module pcfu_top_bench;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {
        logic br;
        logic sk;
        logic irq;
        logic [12:0] tgt;
    } pcfu_row_s;

    localparam pcfu_row_s NORM = '0;
    localparam pcfu_row_s ROWS [12] = '{
        '{1'b0, 1'b0, 1'b0, 13'h0000}, '{1'b0, 1'b0, 1'b0, 13'h0000},
        '{1'b1, 1'b0, 1'b0, 13'h0123}, '{1'b1, 1'b0, 1'b0, 13'h0f00},
        '{1'b0, 1'b0, 1'b0, 13'h0000}, '{1'b0, 1'b1, 1'b0, 13'h0000},
        '{1'b0, 1'b0, 1'b0, 13'h0000}, '{1'b1, 1'b0, 1'b1, 13'h0040},
        '{1'b0, 1'b0, 1'b0, 13'h0000}, '{1'b0, 1'b0, 1'b0, 13'h0000},
        '{1'b1, 1'b0, 1'b0, 13'h0123}, '{1'b0, 1'b0, 1'b0, 13'h0000}};

    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [12:0] pm_addr;
    logic pm_rd;
    logic [15:0] pm_data;
    logic [15:0] instr;
    logic instr_valid;
    logic [1:0] phase;
    logic [12:0] exec_pc;
    logic core_ext = 1'b0;
    logic core_br = 1'b0;
    logic [12:0] core_tgt = 13'h0000;
    logic core_skip = 1'b0;
    logic core_irq = 1'b0;
    logic [12:0] core_vec = 13'h0000;
    int mismatches = 0;
    int num_checks = 0;
    logic [12:0] exp_pm;
    logic [12:0] exp_exec;
    logic exp_v;
    logic pend;
    logic [7:0] pend_w;
    logic [31:0] rd;
    logic er;
    logic [12:0] a;
    int n_w;

    always #2 ref_clk = ~ref_clk;

    pcfu_top #(.HI_W(5)) i_pcfu_top (
        .REF_CLK(ref_clk), .RST_N(rst_n), .PADDR(paddr), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .PM_ADDR(pm_addr), .PM_RD(pm_rd), .PM_DATA(pm_data),
        .INSTR(instr), .INSTR_VALID(instr_valid), .PHASE(phase), .EXEC_PC(exec_pc),
        .CORE_EXTENDED(core_ext), .CORE_BRANCH(core_br), .CORE_TARGET(core_tgt),
        .CORE_SKIP(core_skip), .CORE_IRQ(core_irq), .CORE_VECTOR(core_vec)
    );

    pcfu_pmem_model #(.LAT(2)) i_pcfu_pmem_model (
        .clk(ref_clk), .rd(pm_rd), .addr(pm_addr), .data(pm_data)
    );

    // ==========================================================
    // Tasks
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask: end_of_test

    task automatic do_reset;
        rst_n <= 1'b0;
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        #1;
        `CHK("rst pm_addr", 13'h0000, pm_addr)
        `CHK("rst valid", 1'b0, instr_valid)
        `CHK("rst exec_pc", 13'h0000, exec_pc)
        `CHK("rst phase", 2'd0, phase)
    endtask: do_reset

    task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d,
        input logic [3:0] s);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        pstrb <= s;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20)
        begin
            mismatches++;
            end_of_test();
        end
    endtask: apb

    // Returns at the edge that closes the fourth phase
    task automatic wait_edge(output int n);
        n = 0;
        do
        begin
            @(posedge ref_clk);
            n++;
        end while (phase !== 2'd3 && n < 12);
        if (n >= 12)
        begin
            mismatches++;
            end_of_test();
        end
    endtask: wait_edge

    task automatic cyc(input pcfu_row_s r, input bit chk_n);
        logic [12:0] pc;
        int n;
        core_br <= r.br;
        core_skip <= r.sk;
        core_irq <= r.irq;
        core_tgt <= r.tgt;
        core_vec <= r.tgt + 13'h0010;
        wait_edge(n);
        #1;
        pc = exp_pm + 13'h0001;
        exp_exec = exp_pm;
        if (r.irq)
        begin
            exp_pm = r.tgt + 13'h0010;
            exp_v = 1'b0;
        end
        else if (exp_v && r.br)
        begin
            exp_pm = r.tgt;
            exp_v = 1'b0;
        end
        else if (pend)
        begin
            exp_pm = {pc[12:8], pend_w};
            exp_v = 1'b0;
            pend = 1'b0;
        end
        else
        begin
            exp_pm = pc;
            exp_v = !(exp_v && r.sk);
        end
        if (chk_n)
            `CHK("cycle length", 4, n)
        `CHK("pm_addr", exp_pm, pm_addr)
        `CHK("instr_valid", exp_v, instr_valid)
        `CHK("exec_pc", exp_exec, exec_pc)
        `CHK("fetch strobe", 1'b1, pm_rd)
        if (exp_v)
            `CHK("instr", {3'h5, exp_exec}, instr)
    endtask: cyc

    // ==========================================================
    // Main sequence
    initial
    begin
        do_reset();
        exp_pm = 13'h0000;
        exp_v = 1'b0;
        pend = 1'b0;
        pend_w = 8'h00;
        foreach (ROWS[i])
            cyc(ROWS[i], 1'b1);
        apb(1'b0, pcfu_pkg::PCFU_OFF_SNAP_LOW, 32'h0, 4'h0);
        `CHK("snap low", 32'h00000023, rd)
        `CHK("snap low err", 1'b0, er)
        cyc(NORM, 1'b0);
        cyc('{1'b1, 1'b0, 1'b0, 13'h1f80}, 1'b0);
        cyc(NORM, 1'b0);
        apb(1'b0, pcfu_pkg::PCFU_OFF_SNAP_HIGH, 32'h0, 4'h0);
        `CHK("held high", 32'h00000001, rd)
        cyc(NORM, 1'b0);
        apb(1'b1, pcfu_pkg::PCFU_OFF_SNAP_LOW, 32'h000000ff, 4'h1);
        cyc(NORM, 1'b0);
        apb(1'b0, pcfu_pkg::PCFU_OFF_SNAP_LOW, 32'h0, 4'h0);
        `CHK("snap low ro", {24'h0, exp_exec[7:0]}, rd)
        cyc(NORM, 1'b0);
        apb(1'b0, pcfu_pkg::PCFU_OFF_SNAP_HIGH, 32'h0, 4'h0);
        `CHK("snap high", 32'h0000001f, rd)
        cyc(NORM, 1'b0);
        apb(1'b0, pcfu_pkg::PCFU_OFF_CNT_LOW, 32'h0, 4'h0);
        a = exp_pm + 13'h0001;
        `CHK("counter low", {24'h0, a[7:0]}, rd)
        cyc(NORM, 1'b0);
        apb(1'b1, pcfu_pkg::PCFU_OFF_CNT_LOW, 32'h00000037, 4'h1);
        pend = 1'b1;
        pend_w = 8'h37;
        cyc(NORM, 1'b0);
        cyc(NORM, 1'b0);
        apb(1'b1, pcfu_pkg::PCFU_OFF_CNT_LOW, 32'h00000055, 4'h0);
        cyc(NORM, 1'b0);
        apb(1'b1, pcfu_pkg::PCFU_OFF_CNT_LOW, 32'h00000066, 4'h1);
        pend = 1'b1;
        pend_w = 8'h66;
        cyc('{1'b1, 1'b0, 1'b0, 13'h0200}, 1'b0);
        cyc(NORM, 1'b0);
        cyc(NORM, 1'b0);
        apb(1'b0, 12'h010, 32'h0, 4'h0);
        `CHK("unmapped err", 1'b1, er)
        `CHK("unmapped data", 32'h0, rd)
        cyc(NORM, 1'b0);
        apb(1'b0, pcfu_pkg::PCFU_OFF_STATUS, 32'h0, 4'h0);
        `CHK("status", 32'h00000001, rd)
        a = exp_pm;
        core_ext <= 1'b1;
        wait_edge(n_w);
        core_ext <= 1'b0;
        wait_edge(n_w);
        #1;
        `CHK("extended step", a + 13'h0001, pm_addr)
        do_reset();
        apb(1'b0, pcfu_pkg::PCFU_OFF_SNAP_HIGH, 32'h0, 4'h0);
        `CHK("rst snap high", 32'h0, rd)
        apb(1'b0, pcfu_pkg::PCFU_OFF_SNAP_LOW, 32'h0, 4'h0);
        `CHK("rst snap low", 32'h0, rd)
        end_of_test();
    end
endmodule: pcfu_top_bench
